// ### rtl/mdc_pkg.sv
// Package with constants and types for the motor drive control register bank
package mdc_pkg;

  // Register offsets
  localparam logic [3:0] OFS_CURRENT_LIMIT = 4'h7;
  localparam logic [3:0] OFS_BUCK          = 4'h8;
  localparam logic [3:0] OFS_HALL_BRAKE    = 4'h9;
  localparam logic [3:0] OFS_SPEED_LOCK    = 4'ha;

  // Reset values
  localparam logic [7:0] RST_CURRENT_LIMIT = 8'h00;
  localparam logic [7:0] RST_BUCK          = 8'h00;
  localparam logic [7:0] RST_HALL_BRAKE    = 8'h00;
  localparam logic [7:0] RST_SPEED_LOCK    = 8'h00;

  // Writable bit masks; cleared bits are read-only zero
  localparam logic [7:0] WMASK_CURRENT_LIMIT = 8'hff;
  localparam logic [7:0] WMASK_BUCK          = 8'h3f;
  localparam logic [7:0] WMASK_HALL_BRAKE    = 8'h1f;
  localparam logic [7:0] WMASK_SPEED_LOCK    = 8'hdf;

  // Field positions
  localparam int POS_RECIRC     = 6;
  localparam int POS_ASYNC_RECT = 3;
  localparam int POS_SYNC_RECT  = 2;
  localparam int POS_GAIN       = 0;
  localparam int POS_SEQ_OFF    = 4;
  localparam int POS_REG_ILIM   = 3;
  localparam int POS_REG_VSEL   = 1;
  localparam int POS_REG_OFF    = 0;
  localparam int POS_HYST       = 4;
  localparam int POS_BRAKE_MODE = 3;
  localparam int POS_COAST      = 2;
  localparam int POS_BRAKE      = 1;
  localparam int POS_DIR        = 0;
  localparam int POS_SPEED_DIV  = 6;
  localparam int POS_RETRY_SEL  = 4;
  localparam int POS_DETECT_SEL = 2;
  localparam int POS_RESPONSE   = 0;

  // Stall timing in ms and clock rate in kHz
  localparam int CLK_KHZ      = 40000;
  localparam int DET_MS_0     = 300;
  localparam int DET_MS_1     = 500;
  localparam int DET_MS_2     = 1000;
  localparam int DET_MS_3     = 5000;
  localparam int RETRY_MS_0   = 500;
  localparam int RETRY_MS_1   = 5000;
  localparam int TIMER_W      = 28;

  // Hall edges per speed output toggle, for 3x, 1x, 0.5x, 0.25x
  localparam logic [3:0] SPD_EDGES_0 = 4'h1;
  localparam logic [3:0] SPD_EDGES_1 = 4'h3;
  localparam logic [3:0] SPD_EDGES_2 = 4'h6;
  localparam logic [3:0] SPD_EDGES_3 = 4'hc;

  // Stall response codes
  typedef enum logic [1:0] {
    RESP_LATCH  = 2'h0,
    RESP_RETRY  = 2'h1,
    RESP_REPORT = 2'h2,
    RESP_IGNORE = 2'h3
  } mdc_resp_t;

  // Stall supervisor states, Gray along run -> fault -> retry
  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_LATCHED = 2'b01,
    ST_WAIT    = 2'b11
  } mdc_state_t;

  // Configuration port request
  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } mdc_cfg_req_t;

  // Decoded controls toward power stage and analog
  typedef struct packed {
    logic       recirc_coast;
    logic       async_rect_en;
    logic       sync_rect_en;
    logic [1:0] sense_amp_gain;
    logic       regulator_sequencing_off;
    logic       regulator_current_limit;
    logic [1:0] regulator_vsel;
    logic       regulator_off;
    logic       position_comparator_hysteresis;
    logic       coast_active;
    logic       brake_active;
    logic       dir_ccw;
  } mdc_ctrl_t;

endpackage : mdc_pkg

// ### rtl/mdc_regs.sv
// Motor drive control register bank with stall supervision
`timescale 1ns/1ps
`default_nettype none
module mdc_regs
  import mdc_pkg::*;
#(
  parameter logic [TIMER_W-1:0] DET_CYC_0   = TIMER_W'(DET_MS_0 * CLK_KHZ),
  parameter logic [TIMER_W-1:0] DET_CYC_1   = TIMER_W'(DET_MS_1 * CLK_KHZ),
  parameter logic [TIMER_W-1:0] DET_CYC_2   = TIMER_W'(DET_MS_2 * CLK_KHZ),
  parameter logic [TIMER_W-1:0] DET_CYC_3   = TIMER_W'(DET_MS_3 * CLK_KHZ),
  parameter logic [TIMER_W-1:0] RETRY_CYC_0 = TIMER_W'(RETRY_MS_0 * CLK_KHZ),
  parameter logic [TIMER_W-1:0] RETRY_CYC_1 = TIMER_W'(RETRY_MS_1 * CLK_KHZ)
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire mdc_cfg_req_t cfg_req,
  output logic [7:0]        cfg_rdata,
  input  wire logic         fault_clear_cmd,
  input  wire logic [2:0]   hall_in,
  input  wire logic         motor_driven,
  output mdc_ctrl_t         ctrl,
  output logic [1:0]        speed_pulse_divider,
  output logic              speed_pulse_out,
  output logic              stall_fault,
  output logic              stall_drive_off
);

  logic [7:0]         cur_lim_q;
  logic [7:0]         buck_q;
  logic [7:0]         hall_brk_q;
  logic [7:0]         spd_lock_q;
  logic [7:0]         rdata_q;
  logic [2:0]         hall_s1_q;
  logic [2:0]         hall_s2_q;
  logic [2:0]         hall_s3_q;
  logic [2:0]         hall_acc_q;
  logic               hall_edge;
  logic [3:0]         spd_cnt_q;
  logic [3:0]         spd_edges;
  logic               spd_q;
  logic [TIMER_W-1:0] tmr_q;
  logic [TIMER_W-1:0] det_lim;
  logic [TIMER_W-1:0] retry_lim;
  logic               stall_det;
  logic               fault_q;
  mdc_state_t         state_q;
  mdc_resp_t          resp;

  // Masked write merge, reserved read-only bits stay zero
  function automatic logic [7:0] wmerge(input logic [7:0] wd, input logic [7:0] mask);
    wmerge = wd & mask;
  endfunction : wmerge

  // Write hit decode for one offset
  function automatic logic hit(input mdc_cfg_req_t r, input logic [3:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction : hit

  // Register writes; all return to zero on reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cur_lim_q  <= RST_CURRENT_LIMIT;
      buck_q     <= RST_BUCK;
      hall_brk_q <= RST_HALL_BRAKE;
      spd_lock_q <= RST_SPEED_LOCK;
    end else if (ce) begin
      if (hit(cfg_req, OFS_CURRENT_LIMIT)) begin
        cur_lim_q <= wmerge(cfg_req.wdata, WMASK_CURRENT_LIMIT);
      end
      if (hit(cfg_req, OFS_BUCK)) begin
        buck_q <= wmerge(cfg_req.wdata, WMASK_BUCK);
      end
      if (hit(cfg_req, OFS_HALL_BRAKE)) begin
        hall_brk_q <= wmerge(cfg_req.wdata, WMASK_HALL_BRAKE);
      end
      if (hit(cfg_req, OFS_SPEED_LOCK)) begin
        spd_lock_q <= wmerge(cfg_req.wdata, WMASK_SPEED_LOCK);
      end
    end
  end

  // Registered read-back; unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (ce) begin
      unique case (cfg_req.addr)
        OFS_CURRENT_LIMIT: rdata_q <= cur_lim_q;
        OFS_BUCK:          rdata_q <= buck_q;
        OFS_HALL_BRAKE:    rdata_q <= hall_brk_q;
        OFS_SPEED_LOCK:    rdata_q <= spd_lock_q;
        default:           rdata_q <= 8'h00;
      endcase
    end
  end
  assign cfg_rdata = rdata_q;

  // Field decode toward the power stage and analog trims
  assign ctrl.recirc_coast             = cur_lim_q[POS_RECIRC];
  assign ctrl.async_rect_en            = cur_lim_q[POS_ASYNC_RECT];
  assign ctrl.sync_rect_en             = cur_lim_q[POS_SYNC_RECT];
  assign ctrl.sense_amp_gain           = cur_lim_q[POS_GAIN +: 2];
  assign ctrl.regulator_sequencing_off = buck_q[POS_SEQ_OFF];
  assign ctrl.regulator_current_limit  = buck_q[POS_REG_ILIM];
  assign ctrl.regulator_vsel           = buck_q[POS_REG_VSEL +: 2];
  assign ctrl.regulator_off            = buck_q[POS_REG_OFF];
  assign ctrl.position_comparator_hysteresis = hall_brk_q[POS_HYST];
  assign ctrl.dir_ccw                  = hall_brk_q[POS_DIR];

  // Brake request turns into coast when brake mode says so; coast bit wins
  assign ctrl.coast_active = hall_brk_q[POS_COAST]
                           | (hall_brk_q[POS_BRAKE] & hall_brk_q[POS_BRAKE_MODE]);
  assign ctrl.brake_active = hall_brk_q[POS_BRAKE] & ~hall_brk_q[POS_BRAKE_MODE]
                           & ~hall_brk_q[POS_COAST];

  // Hall pins pass three flops; a state counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hall_s1_q  <= 3'h0;
      hall_s2_q  <= 3'h0;
      hall_s3_q  <= 3'h0;
      hall_acc_q <= 3'h0;
    end else if (ce) begin
      hall_s1_q <= hall_in;
      hall_s2_q <= hall_s1_q;
      hall_s3_q <= hall_s2_q;
      if (hall_s2_q == hall_s3_q) begin
        hall_acc_q <= hall_s3_q;
      end
    end
  end
  assign hall_edge = (hall_s2_q == hall_s3_q) && (hall_s3_q != hall_acc_q);

  // Speed output toggles after a number of accepted Hall edges
  always_comb begin
    unique case (spd_lock_q[POS_SPEED_DIV +: 2])
      2'h0: spd_edges = SPD_EDGES_0;
      2'h1: spd_edges = SPD_EDGES_1;
      2'h2: spd_edges = SPD_EDGES_2;
      2'h3: spd_edges = SPD_EDGES_3;
    endcase
  end
  assign speed_pulse_divider = spd_lock_q[POS_SPEED_DIV +: 2];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      spd_cnt_q <= 4'h0;
      spd_q     <= 1'b0;
    end else if (ce && hall_edge) begin
      if (spd_cnt_q + 4'h1 >= spd_edges) begin
        spd_cnt_q <= 4'h0;
        spd_q     <= ~spd_q;
      end else begin
        spd_cnt_q <= spd_cnt_q + 4'h1;
      end
    end
  end
  assign speed_pulse_out = spd_q;

  // Detection and retry limits from the lock register
  always_comb begin
    unique case (spd_lock_q[POS_DETECT_SEL +: 2])
      2'h0: det_lim = DET_CYC_0;
      2'h1: det_lim = DET_CYC_1;
      2'h2: det_lim = DET_CYC_2;
      2'h3: det_lim = DET_CYC_3;
    endcase
  end
  assign retry_lim = spd_lock_q[POS_RETRY_SEL] ? RETRY_CYC_1 : RETRY_CYC_0;
  assign resp      = mdc_resp_t'(spd_lock_q[POS_RESPONSE +: 2]);

  // One timer serves both stall detection and retry wait
  assign stall_det = (state_q == ST_RUN) && motor_driven && !hall_edge
                   && (tmr_q >= det_lim - TIMER_W'(1));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tmr_q <= '0;
    end else if (ce) begin
      if (state_q == ST_WAIT) begin
        tmr_q <= tmr_q + TIMER_W'(1);
      end else if (hall_edge || !motor_driven || stall_det) begin
        tmr_q <= '0;
      end else if (state_q == ST_RUN) begin
        tmr_q <= tmr_q + TIMER_W'(1);
      end
      if (state_q == ST_WAIT && tmr_q >= retry_lim - TIMER_W'(1)) begin
        tmr_q <= '0;
      end
    end
  end

  // Stall supervisor: latched, retrying, report-only or ignored
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_RUN;
    end else if (ce) begin
      unique case (state_q)
        ST_RUN: begin
          if (stall_det && resp == RESP_LATCH) begin
            state_q <= ST_LATCHED;
          end else if (stall_det && resp == RESP_RETRY) begin
            state_q <= ST_WAIT;
          end
        end
        ST_LATCHED: begin
          if (fault_clear_cmd) begin
            state_q <= ST_RUN;
          end
        end
        ST_WAIT: begin
          if (tmr_q >= retry_lim - TIMER_W'(1)) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // Reported fault flag; a new stall in the clear cycle wins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_q <= 1'b0;
    end else if (ce) begin
      if (stall_det && resp != RESP_IGNORE) begin
        fault_q <= 1'b1;
      end else if (state_q == ST_WAIT && tmr_q >= retry_lim - TIMER_W'(1)) begin
        fault_q <= 1'b0;
      end else if (fault_clear_cmd) begin
        fault_q <= 1'b0;
      end
    end
  end
  assign stall_fault = fault_q;

  // Only latched and retrying responses stop the power stage
  assign stall_drive_off = (state_q != ST_RUN);

endmodule : mdc_regs
`default_nettype wire

// ### testbench/mdc_regs_checker.sv
// Port assertions for the motor drive control register bank
`timescale 1ns/1ps
`default_nettype none
module mdc_regs_checker
  import mdc_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         rstn,
  input wire logic         ce,
  input wire mdc_cfg_req_t cfg_req,
  input wire logic [7:0]   cfg_rdata,
  input wire logic         fault_clear_cmd,
  input wire logic [2:0]   hall_in,
  input wire logic         motor_driven,
  input wire mdc_ctrl_t    ctrl,
  input wire logic [1:0]   speed_pulse_divider,
  input wire logic         speed_pulse_out,
  input wire logic         stall_fault,
  input wire logic         stall_drive_off
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Write as taken; a frozen clock enable takes nothing
  logic       wr_ok;
  logic [7:0] wd;
  assign wr_ok = ce && cfg_req.wr;
  assign wd    = cfg_req.wdata;

  chk_lim_fields: assert property (
    wr_ok && cfg_req.addr == OFS_CURRENT_LIMIT |=> {ctrl.recirc_coast, ctrl.async_rect_en,
    ctrl.sync_rect_en, ctrl.sense_amp_gain} == {$past(wd[6]), $past(wd[3:0])})
    else $error("limit controls differ from write");
  chk_buck_fields: assert property (
    wr_ok && cfg_req.addr == OFS_BUCK |=> {ctrl.regulator_sequencing_off,
    ctrl.regulator_current_limit, ctrl.regulator_vsel, ctrl.regulator_off} == $past(wd[4:0]))
    else $error("regulator controls differ from write");
  chk_hall_fields: assert property (
    wr_ok && cfg_req.addr == OFS_HALL_BRAKE |=> {ctrl.position_comparator_hysteresis,
    ctrl.dir_ccw} == {$past(wd[4]), $past(wd[0])}) else $error("hysteresis or direction");
  chk_coast_mode: assert property (
    wr_ok && cfg_req.addr == OFS_HALL_BRAKE |=> ctrl.coast_active == $past(wd[2] | (wd[1] & wd[3])))
    else $error("coast output wrong");
  chk_brake_mode: assert property (
    wr_ok && cfg_req.addr == OFS_HALL_BRAKE |=> ctrl.brake_active == $past(wd[1] & ~wd[3] & ~wd[2]))
    else $error("brake output wrong");
  chk_div_field: assert property (
    wr_ok && cfg_req.addr == OFS_SPEED_LOCK |=> speed_pulse_divider == $past(wd[7:6]))
    else $error("speed divider differs from write");
  chk_buck_rsv: assert property (
    ce && cfg_req.addr == OFS_BUCK |=> cfg_rdata[7:6] == 2'h0) else $error("buck reserved set");
  chk_hall_rsv: assert property (
    ce && cfg_req.addr == OFS_HALL_BRAKE |=> cfg_rdata[7:5] == 3'h0) else $error("hall reserved");
  chk_unmapped_zero: assert property (
    ce && !(cfg_req.addr inside {[OFS_CURRENT_LIMIT:OFS_SPEED_LOCK]}) |=> cfg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_reset_clean: assert property (
    $rose(rstn) |-> ctrl == '0 && cfg_rdata == 8'h00 && !stall_fault && !stall_drive_off)
    else $error("outputs not clear after reset");
endmodule : mdc_regs_checker

bind mdc_regs mdc_regs_checker u_chk (.ref_clk, .rstn, .ce, .cfg_req, .cfg_rdata,
  .fault_clear_cmd, .hall_in, .motor_driven, .ctrl, .speed_pulse_divider,
  .speed_pulse_out, .stall_fault, .stall_drive_off);
`default_nettype wire

// ### testbench/mdc_regs_tb.sv
// Self-checking bench for the motor drive control register bank
`timescale 1ns/1ps
`default_nettype none
module mdc_regs_tb;
  import mdc_pkg::*;
  logic         ref_clk = 1'b0;
  logic         rstn = 1'b0;
  logic         ce = 1'b1;
  mdc_cfg_req_t cfg_req = '0;
  logic         fault_clear_cmd = 1'b0;
  logic [2:0]   hall_in = 3'h1;
  logic         motor_driven = 1'b0;
  logic [7:0]   cfg_rdata;
  mdc_ctrl_t    ctrl;
  logic [1:0]   div;
  logic         spo, flt, doff;
  logic [7:0]   rd_v;
  int           n_mismatch = 0;
  int           checks = 0;
  int           cyc = 0;
  int           tgl = 0;
  int           hix = 0;
  int           n, n0;
  logic [2:0]   hs [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int           te [4] = '{12, 4, 2, 1};
  // Address, write data, readback expected
  logic [19:0]  rows [11] = '{20'h7_ffff, 20'h7_0000, 20'h8_ff3f, 20'h8_0a0a, 20'h9_ff1f,
    20'h9_0a0a, 20'ha_ffdf, 20'ha_0101, 20'h3_ff00, 20'hb_5a00, 20'hf_ff00};

  // Short timers so stall and retry fit a brief run; longest detection keeps its real length
  mdc_regs #(.DET_CYC_0(28'h8), .DET_CYC_1(28'ha), .DET_CYC_2(28'hc),
    .RETRY_CYC_0(28'h6), .RETRY_CYC_1(28'h9)) dut (.ref_clk, .rstn, .ce, .cfg_req, .cfg_rdata,
    .fault_clear_cmd, .hall_in, .motor_driven, .ctrl, .speed_pulse_divider(div),
    .speed_pulse_out(spo), .stall_fault(flt), .stall_drive_off(doff));

  // Clock at 40 MHz
  always #12.5 ref_clk = ~ref_clk;
  // Speed output edges, counted as they happen
  always @(spo) tgl++;
  // Hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task report_and_stop();
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  // Requests change only at the falling edge
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk) cfg_req = '{1'b1, a, d};
    @(negedge ref_clk) cfg_req.wr = 1'b0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(negedge ref_clk) cfg_req.addr = a;
    @(negedge ref_clk) rd_v = cfg_rdata;
  endtask : rd

  // Bounded wait; a stuck signal just ends the count at 40
  task automatic cnt(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v && k < 40) begin
      @(negedge ref_clk);
      k++;
    end
  endtask : cnt

  task clr();
    @(negedge ref_clk) fault_clear_cmd = 1'b1;
    @(negedge ref_clk) fault_clear_cmd = 1'b0;
  endtask : clr

  task rdall();
    for (int a = 7; a <= 10; a++) begin
      rd(4'(a));
      chk(rd_v, 8'h00);
    end
  endtask : rdall

  initial begin
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    rdall();
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16]);
      chk(rd_v, rows[i][7:0]);
    end
    // Frozen enable must drop the write
    ce = 1'b0;
    wr(OFS_BUCK, 8'h15);
    ce = 1'b1;
    rd(OFS_BUCK);
    chk(rd_v, 8'h0a);
    for (int k = 0; k < 8; k++) begin
      wr(OFS_HALL_BRAKE, {4'h0, 3'(k), 1'b0});
      chk({6'h0, ctrl.coast_active, ctrl.brake_active}, {6'h0, k[1] | (k[0] & k[2]),
        k[0] & ~k[2] & ~k[1]});
    end
    // Hall motion keeps the stall timer clear
    for (int c = 0; c < 4; c++) begin
      wr(OFS_SPEED_LOCK, {2'(c), 6'h0});
      tgl = 0;
      motor_driven = 1'b1;
      repeat (12) begin
        hix = (hix + 1) % 6;
        hall_in = hs[hix];
        repeat (5) @(negedge ref_clk);
      end
      motor_driven = 1'b0;
      repeat (6) @(negedge ref_clk);
      chk(8'(tgl), 8'(te[c]));
      chk({7'h0, flt}, 8'h00);
    end
    for (int d = 0; d < 4; d++) begin
      wr(OFS_SPEED_LOCK, {4'h0, 2'(d), 2'h0});
      motor_driven = 1'b1;
      cnt(flt, 1'b1, n);
      motor_driven = 1'b0;
      clr();
      if (d == 0) n0 = n;
      if (d < 3) chk(8'(n - n0), 8'(2 * d));
      else chk(8'(n), 8'h28);
    end
    for (int m = 0; m < 4; m++) begin
      wr(OFS_SPEED_LOCK, {6'h0, 2'(m)});
      motor_driven = 1'b1;
      cnt(flt, 1'b1, n);
      chk({6'h0, flt, doff}, {6'h0, m != 3, m < 2});
      motor_driven = 1'b0;
      if (m == 1) repeat (20) @(negedge ref_clk);
      else clr();
      chk({6'h0, flt, doff}, 8'h00);
    end
    for (int r = 0; r < 2; r++) begin
      wr(OFS_SPEED_LOCK, {3'h0, 1'(r), 4'h1});
      motor_driven = 1'b1;
      cnt(flt, 1'b1, n);
      motor_driven = 1'b0;
      cnt(doff, 1'b0, n);
      if (r == 0) n0 = n;
      else chk(8'(n - n0), 8'h03);
    end
    @(negedge ref_clk) rstn = 1'b0;
    @(negedge ref_clk) rstn = 1'b1;
    rdall();
    report_and_stop();
  end
endmodule : mdc_regs_tb
`default_nettype wire
